// ===== hdl/irq_core_end.sv
// Core-side end: register access, forced call timing and return
`timescale 1ns/1ns
`default_nettype none
module irq_core_end (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // User side
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [17:0] module_flag_in,
  input wire logic [17:0] flag_clr_in,
  input wire logic return_from_isr_in,
  output logic [7:0] rdata_out,
  output logic [7:0] pc_vector_out,
  output logic vector_valid_out,
  // Link
  irq_link_if.core link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DETECT = 3'b010,
    ST_CALL = 3'b100
  } core_state_t;
  core_state_t state_r;
  logic [2:0] cnt_r;
  logic [7:0] rdata_r, pc_r;
  logic valid_r;

  // Register strobes and flag lines pass straight through
  assign link.reg_wr = wr_in;
  assign link.reg_addr = addr_in;
  assign link.reg_wdata = wdata_in;
  assign link.src_flag = module_flag_in; // RL5 RL19
  assign link.cpu_flag_clr = flag_clr_in; // RL13 RL14 RL17
  assign link.isr_return = return_from_isr_in; // RL8
  assign link.call_start = state_r == ST_DETECT;
  assign link.call_done = state_r == ST_CALL && cnt_r == 3'(irq_pkg::CALL_CYCLES - 1);
  assign rdata_out = rdata_r;
  assign pc_vector_out = pc_r;
  assign vector_valid_out = valid_r;

  // One detect cycle, then six cycles of forced call
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      rdata_r <= 8'h00;
      pc_r <= 8'h00;
      valid_r <= 1'b0;
    end else begin
      rdata_r <= link.reg_rdata;
      valid_r <= link.call_done;
      if (link.call_done) pc_r <= link.irq_vector; // RL6
      unique case (state_r)
        ST_IDLE: begin
          if (link.irq_req) state_r <= ST_DETECT; // RL12
        end
        ST_DETECT: begin
          state_r <= ST_CALL;
          cnt_r <= 3'h0;
        end
        ST_CALL: begin
          cnt_r <= 3'(cnt_r + 3'h1);
          if (link.call_done) state_r <= ST_IDLE; // RL12
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hdl/irq_ctrl.sv
// Interrupt enable, flag, priority nesting and acknowledge controller
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RL1 - Global enable bit 7 gates all acknowledges
// RL2 - Group A enables, reset zero, bit6 unused
// RL3 - Group B enables, bit 6 reads zero
// RL4 - Group C enables, bits 7:6 unused
// RL5 - Audio module masks itself, not here
// RL6 - Enabled interrupt vectors to fixed address
// RL7 - Only strictly higher priority preempts service
// RL8 - Return ends service, restores previous level
// RL9 - Flags set whether enabled or not
// RL10 - Enabled set flag acknowledged next cycle
// RL11 - Lower or equal requests stay pending
// RL12 - Least latency seven cycles: detect, call
// RL13 - Software clears CPU flag before module
// RL14 - Port: module flag before CPU flag
// RL15 - Hardware clears listed flags on vectoring
// RL16 - Remaining enabled module flags re-raise flag; here only a new rising edge on src_flag sets the flag again
// RL17 - Clear one module flag per entry
// RL18 - Vectors from 0x03, eight bytes apart
// RL19 - Peripheral mask needed before flag asserts
// RL20 - Equal priority ties broken by number
module irq_ctrl #(
  parameter int NUM_LEVELS = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Priority level per source, from the priority registers
  input wire logic [2*irq_pkg::NUM_SRC-1:0] src_level_in,
  // Core side
  irq_link_if.ctrl link
);
  localparam int N = irq_pkg::NUM_SRC;
  // Four levels only: the service stack holds one bit per level
  if (NUM_LEVELS != 4) begin
    $error("irq_ctrl supports four priority levels only");
  end

  logic [7:0] group_a_r, group_b_r, group_c_r;
  logic [N-1:0] flag_r, flag_nxt;
  logic [N-1:0] src_d_r;
  logic [3:0] active_r; // One bit per level in service
  logic [4:0] num_r;
  logic [7:0] vec_r;
  logic [1:0] lvl_r;
  logic req_r;
  logic [7:0] rdata_r;
  logic svc_r;

  // Per-source enable vector assembled from the three groups
  logic [N-1:0] src_en;
  always_comb begin
    src_en = '0;
    for (int b = 0; b < 6; b++) begin
      src_en[irq_pkg::src_a(b)] = group_a_r[b]; // RL2
      src_en[irq_pkg::src_b(b)] = group_b_r[b]; // RL3
      src_en[irq_pkg::src_c(b)] = group_c_r[b]; // RL4
    end
  end

  // Address match of one enable register, shared by writes and reads
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Register decode
  wire hit_a = addr_hit(link.reg_addr, irq_pkg::OFS_GROUP_A);
  wire hit_b = addr_hit(link.reg_addr, irq_pkg::OFS_GROUP_B);
  wire hit_c = addr_hit(link.reg_addr, irq_pkg::OFS_GROUP_C);
  wire wr_a = link.reg_wr && hit_a;
  wire wr_b = link.reg_wr && hit_b;
  wire wr_c = link.reg_wr && hit_c;
  wire [7:0] rd_sel = hit_a ? group_a_r :
                      hit_b ? group_b_r :
                      hit_c ? group_c_r : 8'h00; // RL3 RL4

  // Enabled requests and current service level
  wire global_en = group_a_r[irq_pkg::GLOBAL_EN_BIT];
  wire [N-1:0] cand = flag_r & src_en & {N{global_en}}; // RL1
  logic [2:0] cur_lvl; // 0 idle, else level+1 of highest active
  always_comb begin
    cur_lvl = 3'h0;
    for (int l = 0; l < 4; l++) begin
      if (active_r[l]) cur_lvl = 3'(l + 1);
    end
  end

  // Highest level wins, lowest number wins inside a level
  logic [4:0] win_num;
  logic [1:0] win_lvl;
  logic win_ok;
  always_comb begin
    win_num = 5'h00;
    win_lvl = 2'h0;
    win_ok = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i] && (!win_ok || src_level_in[2*i+:2] >= win_lvl)) begin // RL20
        win_num = 5'(i);
        win_lvl = src_level_in[2*i+:2];
        win_ok = 1'b1;
      end
    end
  end
  // Accept only strictly above the level in service; else stay pending
  wire take = win_ok && ({1'b0, win_lvl} >= cur_lvl) && !req_r && !svc_r; // RL7 RL11

  // Peripheral and audio masking is done before the flag lines arrive
  // Flags: source edge sets, software clear, hardware clear on call; set wins
  always_comb begin
    flag_nxt = flag_r & ~link.cpu_flag_clr;
    if (link.call_done && irq_pkg::HW_CLEAR_MASK[num_r]) flag_nxt[num_r] = 1'b0; // RL15
    flag_nxt = flag_nxt | (link.src_flag & ~src_d_r); // RL9 RL16
  end

  // Enable registers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      group_a_r <= irq_pkg::RST_GROUP;
      group_b_r <= irq_pkg::RST_GROUP;
      group_c_r <= irq_pkg::RST_GROUP;
      rdata_r <= 8'h00;
    end else begin
      if (wr_a) group_a_r <= link.reg_wdata & irq_pkg::MASK_GROUP_A; // RL1 RL2
      if (wr_b) group_b_r <= link.reg_wdata & irq_pkg::MASK_GROUP_B; // RL3
      if (wr_c) group_c_r <= link.reg_wdata & irq_pkg::MASK_GROUP_C; // RL4
      rdata_r <= rd_sel;
    end
  end

  // Flags and source edge history
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_r <= '0;
      src_d_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      src_d_r <= link.src_flag;
    end
  end

  // Next request and service state
  logic req_nxt;
  logic svc_nxt;
  always_comb begin
    req_nxt = req_r;
    svc_nxt = svc_r;
    if (take) begin
      req_nxt = 1'b1; // RL10
    end else if (link.call_start) begin
      req_nxt = 1'b0;
      svc_nxt = 1'b1;
    end
    if (link.call_done) begin
      svc_nxt = 1'b0;
    end
  end

  // Nesting stack: a call pushes its level, a return pops the highest
  logic [3:0] active_nxt;
  wire [1:0] top_lvl = 2'(cur_lvl - 3'h1);
  wire pop = link.isr_return && cur_lvl != 3'h0;
  always_comb begin
    active_nxt = active_r;
    if (link.call_done) begin
      active_nxt[lvl_r] = 1'b1;
    end else if (pop) begin
      active_nxt[top_lvl] = 1'b0; // RL8
    end
  end

  // Vector of the winner, latched with it
  wire [7:0] win_vec = irq_pkg::vector_of(win_num); // RL6 RL18

  // Request, service and stack flags
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      req_r <= 1'b0;
      svc_r <= 1'b0;
      active_r <= 4'h0;
    end else begin
      req_r <= req_nxt;
      svc_r <= svc_nxt;
      active_r <= active_nxt;
    end
  end

  // Number, vector and level of the accepted source
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      num_r <= 5'h00;
      vec_r <= 8'h00;
      lvl_r <= 2'h0;
    end else if (take) begin
      num_r <= win_num;
      vec_r <= win_vec;
      lvl_r <= win_lvl;
    end
  end

  // Outputs from flip-flops
  assign link.reg_rdata = rdata_r;
  assign link.cpu_flag = flag_r;
  assign link.irq_req = req_r;
  assign link.irq_num = num_r;
  assign link.irq_vector = vec_r;
  assign link.irq_level = lvl_r;
  assign link.in_service = svc_r;
endmodule
`default_nettype wire

// ===== hdl/irq_link_if.sv
// Interface: the interrupt controller and the processor core side
`timescale 1ns/1ns
`default_nettype none
interface irq_link_if;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [17:0] src_flag;
  logic [17:0] cpu_flag_clr;
  logic [17:0] cpu_flag;
  logic irq_req;
  logic [4:0] irq_num;
  logic [7:0] irq_vector;
  logic [1:0] irq_level;
  logic call_start;
  logic call_done;
  logic isr_return;
  logic in_service;
  modport ctrl (input reg_wr, reg_addr, reg_wdata, src_flag, cpu_flag_clr, call_start,
    call_done, isr_return, output reg_rdata, cpu_flag, irq_req, irq_num, irq_vector,
    irq_level, in_service);
  modport core (output reg_wr, reg_addr, reg_wdata, src_flag, cpu_flag_clr, call_start,
    call_done, isr_return, input reg_rdata, cpu_flag, irq_req, irq_num, irq_vector,
    irq_level, in_service);
endinterface
`default_nettype wire

// ===== hdl/irq_pkg.sv
// Package: enable register map, source numbering, vectors and timing counts
package irq_pkg;
  localparam int NUM_SRC = 18;
  localparam logic [7:0] OFS_GROUP_A = 8'ha8;
  localparam logic [7:0] OFS_GROUP_B = 8'hb8;
  localparam logic [7:0] OFS_GROUP_C = 8'h9a;
  localparam logic [7:0] RST_GROUP = 8'h00;
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] MASK_GROUP_A = 8'hbf;
  localparam logic [7:0] MASK_GROUP_B = 8'hbf;
  localparam logic [7:0] MASK_GROUP_C = 8'h3f;
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STEP = 8'h08;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 6;
  localparam int LATENCY_CYCLES = DETECT_CYCLES + CALL_CYCLES;
  // Sources whose CPU flag hardware clears on vectoring: 0,1,2,3,9,10,11,12
  localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 18'h01e0f;
  // Source number from enable bit position, one table per group
  function automatic logic [4:0] src_a(input int b);
    logic [4:0] t [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05};
    return t[b];
  endfunction
  function automatic logic [4:0] src_b(input int b);
    logic [4:0] t [6] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
    return t[b];
  endfunction
  function automatic logic [4:0] src_c(input int b);
    logic [4:0] t [6] = '{5'h10, 5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11};
    return t[b];
  endfunction
  // Vector address of one source number
  function automatic logic [7:0] vector_of(input logic [4:0] n);
    return 8'(VEC_BASE + ({3'h0, n} << 3));
  endfunction
endpackage

// ===== tb/irq_link_chk.sv
// Checker on the link between controller and core end
`timescale 1ns/1ns
`default_nettype none
module irq_link_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Link signals
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [17:0] src_flag,
  input wire logic [17:0] cpu_flag,
  input wire logic irq_req,
  input wire logic [4:0] irq_num,
  input wire logic [7:0] irq_vector,
  input wire logic call_start,
  input wire logic call_done,
  input wire logic in_service
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic ea_r;
  // Shadow of the global enable bit
  always_ff @(posedge sys_clk_in or posedge reset_in)
    if (reset_in) ea_r <= 1'b0;
    else if (reg_wr && reg_addr == irq_pkg::OFS_GROUP_A) ea_r <= reg_wdata[7];
  // Forced call: one detect cycle, six call cycles
  sequence call_run;
    call_start ##1 in_service [*5] ##1 call_done;
  endsequence
  a_req_to_call: assert property ($rose(irq_req) |=> call_start)
    else $error("request not followed by call start");
  a_call_len: assert property (call_start |-> call_run)
    else $error("forced call length wrong");
  a_vector_map: assert property (irq_req |-> irq_vector == 8'h03 + {irq_num, 3'h0})
    else $error("vector does not match source number");
  a_global_gate: assert property ($rose(irq_req) |-> ea_r)
    else $error("request raised with global enable off");
  a_unused_zero: assert property (reg_addr == 8'h9a |=> reg_rdata[7:6] == 2'h0)
    else $error("unused enable bits read nonzero");
  a_unmapped_zero: assert property (!(reg_addr inside {8'ha8, 8'hb8, 8'h9a}) |=>
    reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_hw_clear: assert property (call_done && irq_pkg::HW_CLEAR_MASK[irq_num] |=>
    !cpu_flag[$past(irq_num)])
    else $error("flag not cleared on vectoring");
  a_flag_sets: assert property ($rose(src_flag[8]) |-> ##[0:2] cpu_flag[8])
    else $error("flag not set by source");
endmodule
`default_nettype wire

// ===== tb/tb_irq_ctrl.sv
// Testbench joining the controller and the core end
`timescale 1ns/1ns
`default_nettype none
module tb_irq_ctrl;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wr_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [17:0] module_flag_in = '0;
  logic [17:0] flag_clr_in = '0;
  logic return_from_isr_in = 1'b0;
  logic [35:0] src_level_in = '0;
  logic [7:0] rdata_out;
  logic [7:0] pc_vector_out;
  logic vector_valid_out;
  int n_mismatch = 0;
  int compares = 0;
  irq_link_if link ();
  irq_ctrl u_irq_ctrl (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .src_level_in(src_level_in), .link(link));
  irq_core_end u_irq_core_end (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .wr_in(wr_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .module_flag_in(module_flag_in),
    .flag_clr_in(flag_clr_in), .return_from_isr_in(return_from_isr_in), .rdata_out(rdata_out),
    .pc_vector_out(pc_vector_out), .vector_valid_out(vector_valid_out), .link(link));
  irq_link_chk u_irq_link_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .src_flag(link.src_flag), .cpu_flag(link.cpu_flag),
    .irq_req(link.irq_req), .irq_num(link.irq_num), .irq_vector(link.irq_vector),
    .call_start(link.call_start), .call_done(link.call_done), .in_service(link.in_service));
  // Clock, 4 ns period
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    cyc(1);
    wr_in = 1'b0;
    cyc(1);
  endtask
  // Read data lands two cycles after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_in = a;
    cyc(2);
    check(rdata_out, exp);
  endtask
  task automatic serve(input logic [7:0] exp);
    int i;
    i = 0;
    while (vector_valid_out !== 1'b1 && i < 40) begin
      cyc(1);
      i++;
    end
    if (i == 40) begin
      n_mismatch++;
      end_of_test();
    end else begin
      check(pc_vector_out, exp);
    end
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      cyc(1);
      check({7'h0, vector_valid_out}, 8'h00);
    end
  endtask
  task automatic done_isr(input int n);
    return_from_isr_in = 1'b1;
    module_flag_in[n] = 1'b0;
    flag_clr_in[n] = 1'b1;
    cyc(1);
    return_from_isr_in = 1'b0;
    flag_clr_in = '0;
    cyc(1);
  endtask
  // Main sequence
  initial begin
    logic [7:0] d;
    int k;
    void'($urandom(32'h996f7f5e));
    cyc(5);
    reset_in = 1'b0;
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h00);
    rd(8'h9a, 8'h00);
    for (k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hff : 8'($urandom);
      wr(8'ha8, d);
      wr(8'hb8, d);
      wr(8'h9a, d);
      rd(8'ha8, d & 8'hbf);
      rd(8'hb8, d & 8'hbf);
      rd(8'h9a, d & 8'h3f);
      rd(8'h5a, 8'h00);
    end
    $display("registers done");
    wr(8'ha8, 8'h3f);
    wr(8'hb8, 8'h3f);
    wr(8'h9a, 8'h3f);
    module_flag_in[8] = 1'b1;
    quiet(12);
    done_isr(8);
    wr(8'ha8, 8'hbf);
    $display("global gate done");
    for (k = 0; k < 18; k++) begin
      module_flag_in[k] = 1'b1;
      serve(8'h03 + 8'(k * 8));
      done_isr(k);
    end
    $display("vectors done");
    src_level_in[11:10] = 2'h1;
    src_level_in[5:4] = 2'h1;
    src_level_in[17:16] = 2'h2;
    module_flag_in[5] = 1'b1;
    serve(8'h2b);
    module_flag_in[2] = 1'b1;
    quiet(12);
    module_flag_in[8] = 1'b1;
    serve(8'h43);
    done_isr(8);
    quiet(6);
    done_isr(5);
    serve(8'h13);
    done_isr(2);
    $display("nesting done");
    src_level_in = '0;
    module_flag_in[12] = 1'b1;
    module_flag_in[9] = 1'b1;
    serve(8'h4b);
    done_isr(9);
    serve(8'h63);
    done_isr(12);
    $display("tie done");
    end_of_test();
  end
endmodule
`default_nettype wire
